// *** hdl/snvms_top.sv ***
// serial nonvolatile memory slave: link-side command engine and system-side latch, status and sleep
//
// What this block does, and what it expects of the host
// (R1) eight-bit opcode from nine; chip select rising early performs nothing
// (R2) 06 sets the write latch, 04 clears it
// (R3) 05 reads status, 01 writes status
// (R4) 03 reads memory, 02 writes memory, 0b is fast read
// (R5) host sends only the nine defined opcodes
// (R6) latch set/clear by commands; writes happen only while latch is set
// (R7) status read repeats the status byte on falling edges, input ignored
// (R8) status write takes eight bits, ignores bits 1 and 0
// (R9) host holds write protect pin steady through a status write
// (R10) read: 24-bit address, upper 7 ignored, data on falling edges
// (R11) each further eight clocks give next byte, address wraps, ends on select rise
// (R12) write: address, then each full byte stored with increment and wrap
// (R13) fast read adds eight dummy bits after the address
// (R14) id read sends four bytes, then holds the last bit
// (R15) sleep entered at select rise after opcode, cancelled by any further rising clock edge
// (R16) asleep: clock and input ignored, output high impedance
// (R17) select falling wakes; normal within 400 us; host no refall meanwhile
// (R18) protect bits pick none, upper quarter, upper half or all; writes refused
// (R19) latch clear refuses all; status locked when lock bit set and pin low
// (R20) pause pin low suspends command, ignores clock and input, output floats
// (R21) host releases pause at the same clock level it started at
// (R22) select rising in pause aborts; unrecognised command leaves latch unchanged
// (R23) latch cleared at reset, on clear command, after status or memory write
// (R24) modes 0 and 3: sample on rising edge, drive on falling edge
// (R25) deselected: inputs ignored, output high impedance
// (R26) status: lock bit 7, spare 6..4, protect 3..2, latch 1, zero 0
// (R27) everything shifted most significant bit first
// (R28) seventeen-bit address counter wraps to zero
`timescale 1ns/1ps
`default_nettype none
`include "snvms_regs.svh"

module snvms_top #(
  parameter int unsigned WAKE_CYCLES = (`SNVMS_WAKE_RECOVERY_US * 1000) / `SNVMS_CLK_PERIOD_NS,
  // arbitrary identity word: maker, continuation, two product bytes
  parameter logic [`SNVMS_ID_BITS-1:0] ID_WORD = 32'h5a7f_c3e1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic serialClk,
  input wire logic chipSelN,
  input wire logic serialIn,
  input wire logic pauseN,
  input wire logic writeProtectN,
  output logic serialOut,
  output logic serialOutEnN,
  output logic sleepActive,
  output logic [`SNVMS_DATA_BITS-1:0] statusByte
);

  localparam logic [4:0] OP_LAST = 5'(`SNVMS_OPCODE_BITS - 1);
  localparam logic [4:0] ADDR_LAST = 5'(`SNVMS_ADDR_FRAME_BITS - 1);
  localparam logic [4:0] DUMMY_LAST = 5'(`SNVMS_DUMMY_BITS - 1);
  localparam logic [4:0] BYTE_LAST = 5'(`SNVMS_DATA_BITS - 1);
  localparam logic [4:0] ID_LAST = 5'(`SNVMS_ID_BITS - 1);
  localparam logic [`SNVMS_WAKE_COUNT_BITS-1:0] WAKE_LAST = `SNVMS_WAKE_COUNT_BITS'(WAKE_CYCLES - 1);
  localparam logic [`SNVMS_ID_BITS-`SNVMS_DATA_BITS-1:0] TX_PAD = '0;

  localparam snvms_pkg::snvms_drive_t DRIVE_IDLE = '{soBit: 1'b0, oeN: 1'b1};
  localparam snvms_pkg::snvms_sys_t SYS_RESET = '{
    csSync1: 1'b1,
    csSync2: 1'b1,
    csPrev: 1'b1,
    wpSync1: 1'b1,
    wpSync2: 1'b1,
    seenTog: 1'b0,
    write_enable_latch: 1'b0,
    nvBits: `SNVMS_STATUS_NV_RESET,
    sleeping: 1'b0,
    recovering: 1'b0,
    recCnt: '0,
    idleOut: 1'b0,
    statusOut: `SNVMS_STATUS_NV_RESET
  };

  snvms_pkg::snvms_frame_t frameState_reg;
  snvms_pkg::snvms_frame_t frameState_next;
  // power-on value; the link clock may not run during rst
  snvms_pkg::snvms_keep_t keepState_reg = '0;
  snvms_pkg::snvms_keep_t keepState_next;
  snvms_pkg::snvms_drive_t driveState_reg;
  snvms_pkg::snvms_drive_t driveState_next;
  snvms_pkg::snvms_sys_t sysState_reg;
  snvms_pkg::snvms_sys_t sysState_next;

  logic [`SNVMS_DATA_BITS-1:0] rxByte;
  logic [`SNVMS_ADDR_BITS-1:0] rxAddr;
  logic [`SNVMS_ADDR_BITS-1:0] loadAddr;
  logic [`SNVMS_ADDR_BITS-1:0] addrInc;
  logic [`SNVMS_DATA_BITS-1:0] memRdData;
  logic [`SNVMS_DATA_BITS-1:0] liveStatus;
  logic memWrEn;
  logic firstEdge;
  logic csRise;
  logic csFall;
  logic statusLocked;

  function automatic logic addrProtected(
    input logic [1:0] bp,
    input logic [`SNVMS_ADDR_BITS-1:0] a
  );
    logic hit;
    hit = 1'b0;
    if (bp == 2'h0) begin
      hit = 1'b0;
    end else if (bp == 2'h1) begin
      hit = (a >= `SNVMS_PROT_QUARTER_BASE);
    end else if (bp == 2'h2) begin
      hit = (a >= `SNVMS_PROT_HALF_BASE);
    end else begin
      hit = 1'b1;
    end
    return hit;
  endfunction : addrProtected

  // msb first: the newest bit lands at the bottom  // see (R27)
  assign rxByte = {frameState_reg.rxShift[`SNVMS_DATA_BITS-2:0], serialIn};
  // upper seven of the 24 address bits are dropped  // see (R10) (R28)
  assign rxAddr = {frameState_reg.rxShift[`SNVMS_ADDR_BITS-2:0], serialIn};
  assign addrInc = `SNVMS_ADDR_BITS'(frameState_reg.addr + `SNVMS_ADDR_BITS'(1));  // see (R28)
  assign firstEdge = (frameState_reg.phase == snvms_pkg::PH_OPCODE) && (frameState_reg.bitCnt == 5'h00);

  // status word from the system side is quasi-static: it only changes while deselected
  assign liveStatus = sysState_reg.nvBits | (`SNVMS_DATA_BITS'(sysState_reg.write_enable_latch) << `SNVMS_ST_WEL_BIT);  // see (R26)

  always_comb begin
    if (frameState_reg.phase == snvms_pkg::PH_ADDR) begin
      loadAddr = rxAddr;
    end else if (frameState_reg.phase == snvms_pkg::PH_DUMMY) begin
      loadAddr = frameState_reg.addr;
    end else begin
      loadAddr = addrInc;
    end
  end

  snvms_mem_array u_mem (
    .clk(serialClk),
    .set_write_latch_cmd(memWrEn),
    .wrAddr(frameState_reg.addr),
    .wrData(rxByte),
    .rdAddr(loadAddr),
    .rdData(memRdData)
  );

  // link side, rising edge: sampling and command sequencing  // see (R24)
  always_comb begin
    frameState_next = frameState_reg;
    keepState_next = keepState_reg;
    keepState_next.idleSync1 = sysState_reg.idleOut;
    keepState_next.idleSync2 = keepState_reg.idleSync1;
    memWrEn = 1'b0;
    // asleep or paused: the edge only moves the idle copy, nothing of the frame  // see (R16) (R20)
    if (pauseN && !keepState_reg.idleSync2) begin
      frameState_next.rxShift = {frameState_reg.rxShift[`SNVMS_ADDR_FRAME_BITS-3:0], serialIn};
      frameState_next.bitCnt = 5'(frameState_reg.bitCnt + 5'h01);
      if (firstEdge) begin
        // a new frame retires the report of the last one
        keepState_next.frameTog = ~keepState_reg.frameTog;
        keepState_next.latchSetF = 1'b0;
        keepState_next.latchClrF = 1'b0;
        keepState_next.writeEndF = 1'b0;
        keepState_next.sleepF = 1'b0;
        keepState_next.statusWrF = 1'b0;
      end
      case (frameState_reg.phase)
        snvms_pkg::PH_OPCODE: begin
          // flags only rise on the eighth bit, so an early select rise leaves nothing  // see (R1) (R22)
          if (frameState_reg.bitCnt == OP_LAST) begin
            frameState_next.bitCnt = 5'h00;
            frameState_next.txCnt = 5'h00;
            frameState_next.phase = snvms_pkg::PH_IGNORE;
            case (rxByte)
              `SNVMS_OP_SET_LATCH: begin
                keepState_next.latchSetF = 1'b1;  // see (R2) (R6)
              end
              `SNVMS_OP_CLR_LATCH: begin
                keepState_next.latchClrF = 1'b1;  // see (R2) (R23)
              end
              `SNVMS_OP_STATUS_RD: begin
                frameState_next.cmd = snvms_pkg::CMD_STATUS_RD;  // see (R3)
                frameState_next.phase = snvms_pkg::PH_OUT;
                frameState_next.tx = {liveStatus, TX_PAD};  // see (R7)
              end
              `SNVMS_OP_STATUS_WR: begin
                frameState_next.cmd = snvms_pkg::CMD_STATUS_WR;  // see (R3)
                frameState_next.phase = snvms_pkg::PH_DATA_IN;
                keepState_next.writeEndF = 1'b1;  // see (R23)
              end
              `SNVMS_OP_MEM_RD: begin
                frameState_next.cmd = snvms_pkg::CMD_MEM_RD;  // see (R4)
                frameState_next.phase = snvms_pkg::PH_ADDR;
              end
              `SNVMS_OP_MEM_WR: begin
                frameState_next.cmd = snvms_pkg::CMD_MEM_WR;  // see (R4)
                frameState_next.phase = snvms_pkg::PH_ADDR;
                keepState_next.writeEndF = 1'b1;  // see (R23)
              end
              `SNVMS_OP_FAST_RD: begin
                frameState_next.cmd = snvms_pkg::CMD_FAST_RD;  // see (R4)
                frameState_next.phase = snvms_pkg::PH_ADDR;
              end
              `SNVMS_OP_ID_RD: begin
                frameState_next.cmd = snvms_pkg::CMD_ID_RD;
                frameState_next.phase = snvms_pkg::PH_OUT;
                frameState_next.tx = ID_WORD;  // see (R14)
              end
              `SNVMS_OP_SLEEP: begin
                keepState_next.sleepF = 1'b1;  // see (R15)
                frameState_next.phase = snvms_pkg::PH_SLEEP_WAIT;
              end
              default: begin
                frameState_next.phase = snvms_pkg::PH_IGNORE;
              end
            endcase
          end
        end
        snvms_pkg::PH_ADDR: begin
          if (frameState_reg.bitCnt == ADDR_LAST) begin
            frameState_next.bitCnt = 5'h00;
            frameState_next.addr = rxAddr;  // see (R10) (R12)
            if (frameState_reg.cmd == snvms_pkg::CMD_MEM_RD) begin
              frameState_next.phase = snvms_pkg::PH_OUT;
              frameState_next.tx = {memRdData, TX_PAD};  // see (R10)
            end else if (frameState_reg.cmd == snvms_pkg::CMD_FAST_RD) begin
              frameState_next.phase = snvms_pkg::PH_DUMMY;  // see (R13)
            end else begin
              frameState_next.phase = snvms_pkg::PH_DATA_IN;
            end
          end
        end
        snvms_pkg::PH_DUMMY: begin
          // dummy bits are counted and thrown away  // see (R13)
          if (frameState_reg.bitCnt == DUMMY_LAST) begin
            frameState_next.bitCnt = 5'h00;
            frameState_next.phase = snvms_pkg::PH_OUT;
            frameState_next.tx = {memRdData, TX_PAD};
          end
        end
        snvms_pkg::PH_DATA_IN: begin
          if (frameState_reg.bitCnt == BYTE_LAST) begin
            frameState_next.bitCnt = 5'h00;
            if (frameState_reg.cmd == snvms_pkg::CMD_STATUS_WR) begin
              // applied at select rise, where the pin and latch are judged  // see (R8)
              keepState_next.statusData = rxByte;
              keepState_next.statusWrF = 1'b1;
            end else begin
              // refused writes still advance the address  // see (R6) (R18) (R19)
              memWrEn = sysState_reg.write_enable_latch &&
                !addrProtected(sysState_reg.nvBits[`SNVMS_ST_BP_HI:`SNVMS_ST_BP_LO], frameState_reg.addr);
              frameState_next.addr = addrInc;  // see (R12)
            end
          end
        end
        snvms_pkg::PH_OUT: begin
          frameState_next.bitCnt = 5'h00;
          if (frameState_reg.cmd == snvms_pkg::CMD_ID_RD) begin
            // past bit 32 the shifter stops, so the last bit stays on the pin  // see (R14)
            if (frameState_reg.txCnt != ID_LAST) begin
              frameState_next.tx = {frameState_reg.tx[`SNVMS_ID_BITS-2:0], 1'b0};
              frameState_next.txCnt = 5'(frameState_reg.txCnt + 5'h01);
            end
          end else if (frameState_reg.txCnt == BYTE_LAST) begin
            frameState_next.txCnt = 5'h00;
            if (frameState_reg.cmd == snvms_pkg::CMD_STATUS_RD) begin
              frameState_next.tx = {liveStatus, TX_PAD};  // see (R7)
            end else begin
              frameState_next.addr = addrInc;  // see (R11) (R28)
              frameState_next.tx = {memRdData, TX_PAD};
            end
          end else begin
            frameState_next.tx = {frameState_reg.tx[`SNVMS_ID_BITS-2:0], 1'b0};  // see (R27)
            frameState_next.txCnt = 5'(frameState_reg.txCnt + 5'h01);
          end
        end
        snvms_pkg::PH_SLEEP_WAIT: begin
          // any rising edge after the opcode cancels; the trailing fall of mode 0 does not  // see (R15)
          keepState_next.sleepF = 1'b0;
          frameState_next.phase = snvms_pkg::PH_IGNORE;
        end
        default: begin
          frameState_next.bitCnt = frameState_reg.bitCnt;
        end
      endcase
    end
  end

  // chip select high clears the frame; the link clock may be stopped then  // see (R25)
  always_ff @(posedge serialClk or posedge chipSelN) begin
    if (chipSelN) begin
      frameState_reg <= '0;
    end else begin
      frameState_reg <= frameState_next;
    end
  end

  always_ff @(posedge serialClk) begin
    keepState_reg <= keepState_next;
  end

  // link side, falling edge: drive the bit prepared on the rising edge  // see (R24)
  always_comb begin
    driveState_next = driveState_reg;
    if (pauseN) begin
      driveState_next.soBit = frameState_reg.tx[`SNVMS_ID_BITS-1];  // see (R7) (R10) (R27)
      driveState_next.oeN = (frameState_reg.phase != snvms_pkg::PH_OUT) || keepState_reg.idleSync2;  // see (R16)
    end
  end

  always_ff @(negedge serialClk or posedge chipSelN) begin
    if (chipSelN) begin
      driveState_reg <= DRIVE_IDLE;  // see (R25)
    end else begin
      driveState_reg <= driveState_next;
    end
  end

  assign serialOut = driveState_reg.soBit;
  // pause floats the pin at once, with no link edge to wait for  // see (R20)
  assign serialOutEnN = driveState_reg.oeN || !pauseN;

  // system side: latch, status bits, sleep and wake recovery
  assign csRise = sysState_reg.csSync2 && !sysState_reg.csPrev;
  assign csFall = !sysState_reg.csSync2 && sysState_reg.csPrev;
  assign statusLocked = sysState_reg.nvBits[`SNVMS_ST_LOCK_BIT] && !sysState_reg.wpSync2;  // see (R19)

  always_comb begin
    sysState_next = sysState_reg;
    sysState_next.csSync1 = chipSelN;
    sysState_next.csSync2 = sysState_reg.csSync1;
    sysState_next.csPrev = sysState_reg.csSync2;
    sysState_next.wpSync1 = writeProtectN;
    sysState_next.wpSync2 = sysState_reg.wpSync1;
    // frame reports are stable by the time the synchronised rise is seen;
    // an unchanged toggle means a frame with no edges, which reports nothing
    if (csRise && (keepState_reg.frameTog != sysState_reg.seenTog)) begin
      sysState_next.seenTog = keepState_reg.frameTog;
      if (keepState_reg.latchSetF) begin
        sysState_next.write_enable_latch = 1'b1;  // see (R6)
      end
      if (keepState_reg.latchClrF) begin
        sysState_next.write_enable_latch = 1'b0;  // see (R6) (R23)
      end
      if (keepState_reg.statusWrF && sysState_reg.write_enable_latch && !statusLocked) begin
        sysState_next.nvBits = keepState_reg.statusData & `SNVMS_ST_NV_MASK;  // see (R8) (R19)
      end
      if (keepState_reg.writeEndF) begin
        sysState_next.write_enable_latch = 1'b0;  // see (R23)
      end
      if (keepState_reg.sleepF) begin
        sysState_next.sleeping = 1'b1;  // see (R15)
      end
    end
    if (csFall && sysState_reg.sleeping) begin
      sysState_next.sleeping = 1'b0;  // see (R17)
      sysState_next.recovering = 1'b1;
      sysState_next.recCnt = '0;
    end else if (sysState_reg.recovering) begin
      // a fresh select fall during recovery is not checked for; host must not do it
      if (sysState_reg.recCnt == WAKE_LAST) begin
        sysState_next.recovering = 1'b0;  // see (R17)
      end else begin
        sysState_next.recCnt = `SNVMS_WAKE_COUNT_BITS'(sysState_reg.recCnt + `SNVMS_WAKE_COUNT_BITS'(1));
      end
    end
    sysState_next.idleOut = sysState_next.sleeping || sysState_next.recovering;  // see (R16)
    sysState_next.statusOut = sysState_next.nvBits |
      (`SNVMS_DATA_BITS'(sysState_next.write_enable_latch) << `SNVMS_ST_WEL_BIT);  // see (R26)
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sysState_reg <= SYS_RESET;  // see (R23)
    end else begin
      sysState_reg <= sysState_next;
    end
  end

  assign sleepActive = sysState_reg.idleOut;
  assign statusByte = sysState_reg.statusOut;

endmodule : snvms_top
`default_nettype wire

// *** hdl/snvms_regs.svh ***
// opcodes, field positions, reset values and timing counts of the serial memory slave
`ifndef SNVMS_REGS_SVH
`define SNVMS_REGS_SVH

`define SNVMS_OP_SET_LATCH 8'h06
`define SNVMS_OP_CLR_LATCH 8'h04
`define SNVMS_OP_STATUS_RD 8'h05
`define SNVMS_OP_STATUS_WR 8'h01
`define SNVMS_OP_MEM_RD 8'h03
`define SNVMS_OP_MEM_WR 8'h02
`define SNVMS_OP_FAST_RD 8'h0b
`define SNVMS_OP_ID_RD 8'h9f
`define SNVMS_OP_SLEEP 8'hb9

`define SNVMS_OPCODE_BITS 8
`define SNVMS_DATA_BITS 8
`define SNVMS_ADDR_FRAME_BITS 24
`define SNVMS_DUMMY_BITS 8
`define SNVMS_ID_BITS 32
`define SNVMS_ADDR_BITS 17
`define SNVMS_MEM_DEPTH 131072

`define SNVMS_ST_LOCK_BIT 7
`define SNVMS_ST_BP_HI 3
`define SNVMS_ST_BP_LO 2
`define SNVMS_ST_WEL_BIT 1
`define SNVMS_ST_NV_MASK 8'hfc
`define SNVMS_STATUS_NV_RESET 8'h00

`define SNVMS_PROT_QUARTER_BASE 17'h18000
`define SNVMS_PROT_HALF_BASE 17'h10000

`define SNVMS_WAKE_RECOVERY_US 400
`define SNVMS_CLK_PERIOD_NS 10
`define SNVMS_WAKE_COUNT_BITS 16

`endif

// *** hdl/snvms_pkg.sv ***
// types of the serial memory slave
`include "snvms_regs.svh"

package snvms_pkg;

  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_ADDR,
    PH_DUMMY,
    PH_DATA_IN,
    PH_OUT,
    PH_SLEEP_WAIT,
    PH_IGNORE
  } snvms_phase_t;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_STATUS_RD,
    CMD_STATUS_WR,
    CMD_MEM_RD,
    CMD_MEM_WR,
    CMD_FAST_RD,
    CMD_ID_RD
  } snvms_cmd_t;

  // link state, cleared by chip select high
  typedef struct packed {
    snvms_phase_t phase;
    snvms_cmd_t cmd;
    logic [4:0] bitCnt;
    logic [`SNVMS_ADDR_FRAME_BITS-2:0] rxShift;
    logic [`SNVMS_ADDR_BITS-1:0] addr;
    logic [`SNVMS_ID_BITS-1:0] tx;
    logic [4:0] txCnt;
  } snvms_frame_t;

  // link state that outlives the frame: reports read by the system side after chip select rises, and the link-side copy of the idle flag
  typedef struct packed {
    logic frameTog;
    logic latchSetF;
    logic latchClrF;
    logic writeEndF;
    logic sleepF;
    logic statusWrF;
    logic [`SNVMS_DATA_BITS-1:0] statusData;
    logic idleSync1;
    logic idleSync2;
  } snvms_keep_t;

  typedef struct packed {
    logic soBit;
    logic oeN;
  } snvms_drive_t;

  typedef struct packed {
    logic csSync1;
    logic csSync2;
    logic csPrev;
    logic wpSync1;
    logic wpSync2;
    logic seenTog;
    logic write_enable_latch;
    logic [`SNVMS_DATA_BITS-1:0] nvBits;
    logic sleeping;
    logic recovering;
    logic [`SNVMS_WAKE_COUNT_BITS-1:0] recCnt;
    logic idleOut;
    logic [`SNVMS_DATA_BITS-1:0] statusOut;
  } snvms_sys_t;

endpackage : snvms_pkg

// *** hdl/snvms_mem_array.sv ***
// byte array of the serial memory, written on the link clock, read asynchronously
`timescale 1ns/1ps
`default_nettype none
`include "snvms_regs.svh"

module snvms_mem_array (
  input wire logic clk,
  input wire logic set_write_latch_cmd,
  input wire logic [`SNVMS_ADDR_BITS-1:0] wrAddr,
  input wire logic [`SNVMS_DATA_BITS-1:0] wrData,
  input wire logic [`SNVMS_ADDR_BITS-1:0] rdAddr,
  output logic [`SNVMS_DATA_BITS-1:0] rdData
);

  // contents are not cleared by reset, like the real cells
  logic [`SNVMS_DATA_BITS-1:0] cells [0:`SNVMS_MEM_DEPTH-1];

  always_ff @(posedge clk) begin
    if (set_write_latch_cmd) begin
      cells[wrAddr] <= wrData;
    end
  end

  assign rdData = cells[rdAddr];

endmodule : snvms_mem_array
`default_nettype wire

// *** verif/snvms_checker.sv ***
// port assertions of the serial memory slave
`timescale 1ns/1ps
`default_nettype none
`include "snvms_regs.svh"
module snvms_checker #(
  parameter int unsigned WAKE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic serialClk,
  input wire logic chipSelN,
  input wire logic serialIn,
  input wire logic pauseN,
  input wire logic writeProtectN,
  input wire logic serialOut,
  input wire logic serialOutEnN,
  input wire logic sleepActive,
  input wire logic [`SNVMS_DATA_BITS-1:0] statusByte
);
  // window allows the 2ff wake sync plus the output register
  localparam int W_LO = WAKE_CYCLES - 8;
  localparam int W_HI = WAKE_CYCLES;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_desel; chipSelN |-> serialOutEnN; endproperty
  a_desel: assert property (p_desel) else $error("driven while deselected");
  property p_pause; !pauseN && !chipSelN |-> serialOutEnN; endproperty
  a_pause: assert property (p_pause) else $error("driven during pause");
  property p_edge; $changed(serialOut) |-> !serialClk || chipSelN; endproperty
  a_edge: assert property (p_edge) else $error("output moved off falling edge");
  property p_rst; $fell(rst) |-> statusByte == 8'h00 && !sleepActive; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_sleep; $rose(sleepActive) |-> chipSelN && $past(chipSelN, 2); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep without select rise");
  property p_wake; $fell(chipSelN) && sleepActive |-> sleepActive[*8] ##[W_LO:W_HI] !sleepActive; endproperty
  a_wake: assert property (p_wake) else $error("wake recovery length wrong");
  property p_lock; (statusByte[7] && !writeProtectN)[*8] |=> $stable(statusByte[7:2]); endproperty
  a_lock: assert property (p_lock) else $error("locked status changed");
  property p_latch; $changed(statusByte[1]) |-> chipSelN; endproperty
  a_latch: assert property (p_latch) else $error("latch moved inside frame");
endmodule : snvms_checker
`default_nettype wire

// *** verif/snvms_host_model.sv ***
// host spi master model, mode 0, 64 ns link clock
`timescale 1ns/1ps
`default_nettype none
module snvms_host_model (
  output logic serialClk,
  output logic chipSelN,
  output logic serialIn,
  output logic pauseN,
  input wire logic soPin
);
  initial begin
    serialClk = 1'b0;
    chipSelN = 1'b1;
    serialIn = 1'b0;
    pauseN = 1'b1;
  end
  // clock stands still outside frames
  task automatic xfer(input logic [95:0] tx, input int n, input int pauseAt, output logic [63:0] rx);
    rx = '0;
    chipSelN = 1'b0;
    #32;
    for (int i = 0; i < n; i++) begin
      if (i == pauseAt) begin
        // settle past the falling edge so that edge still drives its bit
        #8 pauseN = 1'b0;  // entered and left with the clock low
        repeat (4) begin
          serialIn = ~serialIn;
          #32 serialClk = 1'b1;
          #32 serialClk = 1'b0;
        end
        #32 pauseN = 1'b1;
      end
      serialIn = tx[95 - i];  // msb first, set after the falling edge
      #32 serialClk = 1'b1;
      rx = {rx[62:0], soPin};
      #32 serialClk = 1'b0;
    end
    serialIn = ~serialIn;
    #32 chipSelN = 1'b1;
    #256;  // deselect long enough, never refalls during recovery
  endtask : xfer
endmodule : snvms_host_model
`default_nettype wire

// *** verif/tb_snvms_top.sv ***
// self-checking bench of the serial memory slave
`timescale 1ns/1ps
`default_nettype none
module tb_snvms_top;
  logic clk, rst, writeProtectN, serialClk, chipSelN, serialIn, pauseN;
  logic serialOut, serialOutEnN, sleepActive;
  logic [7:0] statusByte;
  logic [63:0] rx;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  wire soPin = serialOutEnN ? 1'bz : serialOut;
  snvms_top #(.WAKE_CYCLES(20), .ID_WORD(32'h3c5a_96e1)) snvms_top_inst (.clk(clk), .rst(rst),
    .serialClk(serialClk), .chipSelN(chipSelN), .serialIn(serialIn), .pauseN(pauseN),
    .writeProtectN(writeProtectN), .serialOut(serialOut), .serialOutEnN(serialOutEnN),
    .sleepActive(sleepActive), .statusByte(statusByte));
  snvms_host_model snvms_host_model_inst (.serialClk(serialClk), .chipSelN(chipSelN),
    .serialIn(serialIn), .pauseN(pauseN), .soPin(soPin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      $display("mismatch at %0t: timeout", $time);
      final_report();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkSt(input logic [7:0] e);
    chk({56'h0, statusByte}, {56'h0, e});
  endtask : chkSt
  // only the nine defined opcodes are ever sent
  task automatic send(input logic [95:0] tx, input int n, input int pauseAt = 99);
    snvms_host_model_inst.xfer(tx, n, pauseAt, rx);
  endtask : send
  task automatic setLatch;
    send({8'h06, 88'h0}, 8);
  endtask : setLatch
  task automatic wrStatus(input logic [7:0] v);
    setLatch();
    send({8'h01, v, 80'h0}, 16);
  endtask : wrStatus
  task automatic testLatch;
    send({8'h06, 88'h0}, 4);
    chkSt(8'h00);
    setLatch();
    chkSt(8'h02);
    send({8'h05, 88'h0}, 24, 12);
    chk(rx, 64'h00zz_0202);
    send({8'h04, 88'h0}, 8);
    chkSt(8'h00);
    $display("latch test done");
  endtask : testLatch
  task automatic testStatus;
    wrStatus(8'hff);
    chkSt(8'hfc);
    send({8'h01, 88'h0}, 16);
    chkSt(8'hfc);
    @(negedge clk) writeProtectN = 1'b0;  // held across the frame
    wrStatus(8'h00);
    chkSt(8'hfc);
    @(negedge clk) writeProtectN = 1'b1;
    wrStatus(8'h00);
    chkSt(8'h00);
    $display("status test done");
  endtask : testStatus
  task automatic testMem;
    logic [39:0] tbl [4] = '{40'h88_d1e2_22e2, 40'h04_f3a4_22a4, 40'h0c_b5c6_22a4, 40'h00_9788_9788};
    setLatch();
    send({8'h02, 24'hfffffe, 32'h11223344, 32'h0}, 68);
    chkSt(8'h00);
    send({8'h0b, 24'h81fffe, 8'h5a, 56'h0}, 72);
    chk(rx, {32'hzzzzzzzz, 32'h11223344});
    for (int i = 0; i < 4; i++) begin
      wrStatus(tbl[i][39:32]);
      chkSt(tbl[i][39:32]);
      setLatch();
      send({8'h02, 24'h01ffff, tbl[i][31:16], 48'h0}, 48);
      send({8'h03, 24'hffffff, 64'h0}, 48);
      chk(rx, {16'h0, 32'hzzzzzzzz, tbl[i][15:0]});
    end
    $display("memory test done");
  endtask : testMem
  task automatic testIdSleep;
    send({8'h9f, 88'h0}, 48);
    chk(rx, 64'h00zz_3c5a_96e1_ff);
    send({8'hb9, 88'h0}, 9);
    chk({63'h0, sleepActive}, 64'h0);
    send({8'hb9, 88'h0}, 8);
    chk({63'h0, sleepActive}, 64'h1);
    send({8'h05, 88'h0}, 2);
    chk(rx, {62'h0, 2'bzz});
    for (int i = 0; i < 100 && sleepActive; i++) @(posedge clk);
    chk({63'h0, sleepActive}, 64'h0);
    @(negedge clk);
    // idle copy on the link side only moves on link edges: a cut frame of two clocks clears it
    send({8'h05, 88'h0}, 2);
    send({8'h05, 88'h0}, 16);
    chk(rx, 64'h00zz_00);
    $display("id and sleep test done");
  endtask : testIdSleep
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  initial begin
    rst = 1'b1;
    writeProtectN = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    testLatch();
    testStatus();
    testMem();
    testIdSleep();
    final_report();
  end
endmodule : tb_snvms_top
bind snvms_top snvms_checker #(.WAKE_CYCLES(WAKE_CYCLES)) snvms_checker_inst (.clk(clk), .rst(rst),
  .serialClk(serialClk), .chipSelN(chipSelN), .serialIn(serialIn), .pauseN(pauseN),
  .writeProtectN(writeProtectN), .serialOut(serialOut), .serialOutEnN(serialOutEnN),
  .sleepActive(sleepActive), .statusByte(statusByte));
`default_nettype wire
